// ---- include/blit_pkg.sv ----
// Package: register map, field positions and types of the block transfer control and status bank.
// Assumes a single clock domain and an AHB-Lite slave with 32-bit data.
package blit_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [15:0] CTRL_OFFSET = 16'h8000;
   localparam logic [15:0] STATUS_OFFSET = 16'h8004;
   localparam logic [15:0] LINE_OFFSET_OFFSET = 16'h8014;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   localparam logic [31:0] STATUS_RESET = 32'h00000000;
   localparam logic [15:0] LINE_OFFSET_RESET = 16'h0000;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int START_BIT = 0;
   localparam int SRC_LINEAR_BIT = 16;
   localparam int DST_LINEAR_BIT = 17;
   localparam int COLOR_16_BIT = 18;
   localparam int BUSY_BIT = 0;
   localparam int FULL_BIT = 4;
   localparam int HALF_BIT = 5;
   localparam int NOT_EMPTY_BIT = 6;
   localparam int USED_LSB = 24;
   localparam int FREE_LSB = 16;

   // ----------------------------------------
   // FIFO thresholds
   // ----------------------------------------
   localparam logic [4:0] FIFO_DEPTH = 5'h10;
   localparam logic [4:0] HALF_LEVEL = 5'h07;
   localparam logic [4:0] FULL_LEVEL = 5'h0F;
   localparam logic [4:0] RESUME_LEVEL = 5'h0E;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic colorSixteen;
      logic dstLinear;
      logic srcLinear;
   } config_type;

   typedef struct packed {
      logic [31:0] addr;
      logic write;
      logic [1:0] trans;
   } ahb_addr_type;

endpackage : blit_pkg

// ---- hdl/blit_engine_control_status.sv ----
// Control and status register bank of the block transfer engine, AHB-Lite slave.
// Assumes the datapath reports FIFO occupancy and completion synchronously to clk.
`timescale 1ns/10ps
`default_nettype none
module blit_engine_control_status
   import blit_pkg::*;
(
   // Clock, reset and enable
   input wire logic clk,
   input wire logic srst,
   input wire logic clkEn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Datapath side
   input wire logic opDone,
   input wire logic readOp,
   input wire logic [4:0] fifoUsed,
   output logic startPulse,
   output logic colorSixteen,
   output logic dstLinear,
   output logic srcLinear,
   output logic [15:0] lineOffset,
   output logic readPause
);

   // ----------------------------------------
   // Address phase capture
   // ----------------------------------------
   logic wrPend_q;
   logic [15:0] wrAddr_q;
   config_type cfg_q;
   logic running_q;
   logic pause_q;
   logic [15:0] lineOffset_q;
   logic startPulse_q;
   logic [31:0] hrdata_q;
   ahb_addr_type req;

   assign req = '{addr: haddr, write: hwrite, trans: htrans};

   wire addrPhase = hsel && hready && req.trans[1];
   wire rdReq = addrPhase && !req.write;
   wire wrReq = addrPhase && req.write;
   wire wrCtrl = wrPend_q && (wrAddr_q == CTRL_OFFSET);
   wire wrLine = wrPend_q && (wrAddr_q == LINE_OFFSET_OFFSET);
   // A zero written to start while running is ignored; software must not rely on it.
   wire launch = wrCtrl && hwdata[START_BIT];

   // ----------------------------------------
   // FIFO status decode
   // ----------------------------------------
   wire [4:0] freeCount = FIFO_DEPTH - fifoUsed;
   wire isFull = fifoUsed >= FULL_LEVEL;
   wire isHalf = fifoUsed >= HALF_LEVEL;
   wire notEmpty = fifoUsed != 5'h00;
   wire pauseSet = readOp && running_q && (fifoUsed == FIFO_DEPTH);
   wire pauseClr = fifoUsed < RESUME_LEVEL;

   wire [31:0] statusWord = {3'h0, fifoUsed, 3'h0, freeCount, 9'h000,
                             notEmpty, isHalf, isFull, 3'h0, running_q};
   // Start reads back as zero; completion is only visible through the busy flag.
   wire [31:0] ctrlWord = {13'h0000, cfg_q, 16'h0000};
   wire [31:0] rdMux = (haddr[15:0] == STATUS_OFFSET) ? statusWord :
                       (haddr[15:0] == CTRL_OFFSET) ? ctrlWord :
                       (haddr[15:0] == LINE_OFFSET_OFFSET) ? {16'h0000, lineOffset_q} :
                       32'h00000000;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 16'h0000;
         hrdata_q <= 32'h00000000;
         startPulse_q <= 1'b0;
      end else if (clkEn) begin
         wrPend_q <= wrReq;
         wrAddr_q <= haddr[15:0];
         hrdata_q <= rdReq ? rdMux : 32'h00000000;
         startPulse_q <= launch && !running_q;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cfg_q <= config_type'(CTRL_RESET[18:16]);
         lineOffset_q <= LINE_OFFSET_RESET;
      end else if (clkEn) begin
         if (wrCtrl && !running_q) begin
            cfg_q.colorSixteen <= hwdata[COLOR_16_BIT];
            cfg_q.dstLinear <= hwdata[DST_LINEAR_BIT];
            cfg_q.srcLinear <= hwdata[SRC_LINEAR_BIT];
         end
         if (wrLine) begin
            lineOffset_q <= hwdata[15:0];
         end
      end
   end

   // Launch wins over a same-cycle completion, but no start pulse issues if running_q was still set.
   always_ff @(posedge clk) begin
      if (srst) begin
         running_q <= STATUS_RESET[BUSY_BIT];
         pause_q <= 1'b0;
      end else if (clkEn) begin
         if (launch) begin
            running_q <= 1'b1;
         end else if (opDone) begin
            running_q <= 1'b0;
         end
         if (pauseSet) begin
            pause_q <= 1'b1;
         end else if (pauseClr || !running_q) begin
            pause_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign hrdata = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign startPulse = startPulse_q;
   assign colorSixteen = cfg_q.colorSixteen;
   assign dstLinear = cfg_q.dstLinear;
   assign srcLinear = cfg_q.srcLinear;
   assign lineOffset = lineOffset_q;
   assign readPause = pause_q;

endmodule : blit_engine_control_status
`default_nettype wire

// ---- test/blit_cs_assertions.sv ----
// Checker of the transfer register bank ports.
// Bound by name onto the bank; one clock, zero-wait bus.
`timescale 1ns/10ps
`default_nettype none
module blit_cs_assertions
   import blit_pkg::*;
(
   input wire logic clk, srst, clkEn, hsel, hwrite, hready, readOp,
   input wire logic startPulse, colorSixteen, dstLinear, srcLinear, readPause,
   input wire logic [31:0] haddr, hwdata, hrdata,
   input wire logic [1:0] htrans,
   input wire logic [4:0] fifoUsed,
   input wire logic [15:0] lineOffset
);
   logic wr_q, rd_q;
   wire logic take = hsel && hready && htrans[1] && clkEn;
   always_ff @(posedge clk) begin
      wr_q <= !srst && take && hwrite && haddr[15:0] == CTRL_OFFSET;
      rd_q <= !srst && take && !hwrite && haddr[15:0] == STATUS_OFFSET;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   AST_CFG: assert property ($changed({colorSixteen, dstLinear, srcLinear})
      |-> $past(wr_q)) else $error("config moved");
   AST_START: assert property (startPulse |-> $past(wr_q && hwdata[START_BIT])
      ##1 !startPulse) else $error("bad start");
   AST_USED: assert property (rd_q |-> hrdata[28:24] == $past(fifoUsed))
      else $error("used field");
   AST_FREE: assert property (rd_q |-> hrdata[20:16] == 5'h10 - $past(fifoUsed))
      else $error("free field");
   AST_FLAGS: assert property (rd_q |-> hrdata[6:4] == {$past(fifoUsed) > 5'h00,
      $past(fifoUsed) > 5'h06, $past(fifoUsed) > 5'h0E}) else $error("flags");
   AST_PSET: assert property ($rose(readPause) |-> $past(readOp && fifoUsed == 5'h10))
      else $error("pause set");
   AST_PHOLD: assert property (clkEn && readPause && fifoUsed < 5'h0E |=> !readPause)
      else $error("pause held");
   AST_RST: assert property (disable iff (1'b0) srst |=> !{startPulse, colorSixteen,
      dstLinear, srcLinear, readPause} && lineOffset == 16'h0000) else $error("reset");
endmodule : blit_cs_assertions
bind blit_engine_control_status blit_cs_assertions chk (.clk, .srst, .clkEn, .hsel, .hwrite,
   .hready, .readOp, .startPulse, .colorSixteen, .dstLinear, .srcLinear, .readPause, .haddr,
   .hwdata, .hrdata, .htrans, .fifoUsed, .lineOffset);
`default_nettype wire

// ---- test/tb_top.sv ----
// Bench driving the bank over AHB-Lite and the datapath inputs.
// Assumes a zero-wait slave; clkEn is high except in the one freeze scenario.
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import blit_pkg::*;
;
   logic clk = 0, srst = 1, hsel = 0, hwrite = 0, opDone = 0, readOp = 0, clkEn = 1;
   logic [1:0] htrans = 2'h0;
   logic [4:0] fifoUsed = 5'h00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
   logic hreadyout, hresp, startPulse, colorSixteen, dstLinear, srcLinear, readPause;
   logic [15:0] lineOffset;
   int err_count = 0, check_count = 0, cyc = 0;
   initial forever #4 clk = ~clk;
   blit_engine_control_status dut (.clk, .srst, .clkEn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .opDone, .readOp,
      .fifoUsed, .startPulse, .colorSixteen, .dstLinear, .srcLinear, .lineOffset, .readPause);
   task automatic chk(input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic [31:0] a, d, input logic w);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer
   function automatic logic [31:0] st(input logic [4:0] u, input logic b);
      st = {3'h0, u, 3'h0, 5'h10 - u, 9'h0, u > 5'h00, u > 5'h06, u > 5'h0E, 3'h0, b};
   endfunction : st
   task automatic summarize();
      if (err_count == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   // A hung handshake would stall the sequence, so a cycle ceiling ends it.
   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         err_count++;
         summarize();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      xfer(32'h8000, 32'h0, 1'b0);
      chk(rd, 32'h0);
      for (int u = 0; u <= 16; u++) begin
         fifoUsed <= u[4:0];
         xfer(32'h8004, 32'h0, 1'b0);
         chk(rd, st(u[4:0], 1'b0));
      end
      for (int c = 0; c < 8; c++) begin
         xfer(32'h8000, {13'h0, c[2:0], 16'h0}, 1'b1);
         @(posedge clk);
         chk({colorSixteen, dstLinear, srcLinear}, c[2:0]);
      end
      readOp <= 1'b1;
      xfer(32'h8000, 32'h00050001, 1'b1);
      @(posedge clk);
      chk({startPulse, colorSixteen, dstLinear, srcLinear}, 4'hD);
      xfer(32'h8004, 32'h0, 1'b0);
      chk(rd, st(5'h10, 1'b1));
      xfer(32'h8000, 32'h00000001, 1'b1);
      @(posedge clk);
      chk({startPulse, colorSixteen, dstLinear, srcLinear, readPause}, 5'h0B);
      fifoUsed <= 5'h0E;
      repeat (2) @(posedge clk);
      chk(readPause, 1'b1);
      fifoUsed <= 5'h0D;
      repeat (2) @(posedge clk);
      chk(readPause, 1'b0);
      opDone <= 1'b1;
      @(posedge clk);
      opDone <= 1'b0;
      xfer(32'h8004, 32'h0, 1'b0);
      chk(rd, st(5'h0D, 1'b0));
      xfer(32'h8014, 32'h0000A5C3, 1'b1);
      @(posedge clk);
      chk(lineOffset, 16'hA5C3);
      xfer(32'h8008, 32'hFFFFFFFF, 1'b1);
      xfer(32'h8008, 32'h0, 1'b0);
      chk(rd, 32'h0);
      xfer(32'h8000, 32'h0, 1'b0);
      chk(rd, 32'h00050000);
      // A frozen bank must ignore a whole transfer, so the layout stays as last written.
      clkEn <= 1'b0;
      xfer(32'h8000, 32'h00020000, 1'b1);
      clkEn <= 1'b1;
      @(posedge clk);
      chk({colorSixteen, dstLinear, srcLinear}, 3'h5);
      summarize();
   end
endmodule : tb_top
`default_nettype wire
